// *** drss_pkg.sv ***
// Package for the DDR read resynchronization block.
// Assumes one fast base clock; phase figures are given in degrees and turned into ticks of that clock.
package drss_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] DRSS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DRSS_OFS_WINDOW = 8'h04;
  localparam logic [7:0] DRSS_OFS_STATUS = 8'h08;
  localparam logic [7:0] DRSS_OFS_COUNT  = 8'h0c;

  // Control register fields.
  localparam int DRSS_CTRL_STROBELESS = 0;
  localparam int DRSS_CTRL_AUTO       = 1;
  localparam int DRSS_CTRL_SEL_LSB    = 2;
  localparam int DRSS_CTRL_CYC_LSB    = 4;
  localparam int DRSS_CTRL_PHASE_LSB  = 8;
  localparam int DRSS_CTRL_ADJ_LSB    = 16;
  localparam int DRSS_CTRL_LAT_LSB    = 24;
  localparam logic [31:0] DRSS_CTRL_RESET   = 32'h0000_0002;
  localparam logic [31:0] DRSS_WINDOW_RESET = 32'h0000_0000;

  // Window register fields, both in base clock ticks.
  localparam int DRSS_WIN_MIN_LSB = 0;
  localparam int DRSS_WIN_MAX_LSB = 16;

  // Status register fields.
  localparam int DRSS_ST_NUMCYC_LSB = 0;
  localparam int DRSS_ST_EDGE_OK    = 8;
  localparam int DRSS_ST_WIDE_OK    = 9;
  localparam int DRSS_ST_SEL_LSB    = 10;
  localparam int DRSS_ST_BUSY       = 12;
  localparam int DRSS_ST_FBPH_LSB   = 16;
  localparam int DRSS_ST_PHASE_LSB  = 24;

  // Timing figures.
  localparam int DRSS_CLK_PERIOD_PS = 8000;
  localparam int DRSS_PLL_SKEW_PS   = 150;
  localparam int DRSS_STROBE_DEG    = 72;
  localparam int DRSS_READ_DEG      = 90;
  localparam int DRSS_WRITE_DEG     = -90;
  localparam int DRSS_FULL_DEG      = 360;

  // Resynchronization clock choices.
  typedef enum logic [1:0] {
    DRSS_EDGE_RISE,
    DRSS_EDGE_FALL,
    DRSS_EDGE_SHIFT,
    DRSS_EDGE_SHIFT_INV
  } drss_edge_t;

endpackage : drss_pkg

// *** drss_top.sv ***
// Read data capture and resynchronization into the system clock domain.
// Assumes CLK is a base clock that the memory clocks are divided from, an APB master
// on CLK, and DQ, DQS and the looped feedback clock arriving asynchronously on pins.
//
// Overview of operation
// [RULE1] Latch high word on shifted strobe rise, realign.
// [RULE2] Resync clock: system, shifted or own, invertible.
// [RULE3] Capture hands pair over on strobe fall.
// [RULE4] Memory takes read at rising edge, time zero.
// [RULE5] Half-cycle count is ceiling of earliest time.
// [RULE6] System edge only if count inside window.
// [RULE7] Even count without extra clock: rising edge.
// [RULE8] Odd count without extra clock: falling edge.
// [RULE9] Extra clock from nearest edge by parity.
// [RULE10] Safe window must exceed PLL skew figure.
// [RULE11] Falling-referenced phase offset by half period.
// [RULE12] Cycle zero: first rise after first strobe fall.
// [RULE13] Each cycle step delays one system period.
// [RULE14] Phase applies when no edge in window.
// [RULE15] Write side makes system, write, feedback clocks.
// [RULE16] Read clock tracks looped feedback clock phase.
// [RULE17] Strobe-less mode ignores strobe, uses read clock.
// [RULE18] Read clock adjusted, shifted ninety degrees.
// [RULE19] Both words resynchronized together in one edge.
// [RULE20] Settings change only with no read in flight; the window register applies at once.
//
// Implementation choices: the address map and the APB slave port.
module drss_top
  import drss_pkg::*;
#(
  parameter int DQ_WIDTH      = 8,
  parameter int HALF_TICKS    = 4,
  parameter int BURST_PAIRS   = 4,
  parameter int TIMEOUT_TICKS = 1024
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // APB slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // Read request from the controller
  input  wire logic                  READ_REQ,
  output logic                       READ_BUSY,
  output logic                       MEM_READ_CMD,
  // Memory read pins
  input  wire logic                  DQS_IN,
  input  wire logic [DQ_WIDTH-1:0]   DQ_IN,
  // Generated clocks and loopback
  output logic                       SYS_CLK_OUT,
  output logic                       WRITE_CLK_OUT,
  output logic                       LOOPBACK_FEEDBACK_CLOCK_OUT,
  input  wire logic                  LOOPBACK_FEEDBACK_CLOCK_IN,
  // Resynchronized read data
  output logic      [2*DQ_WIDTH-1:0] RD_DATA,
  output logic                       RD_VALID
);

  localparam logic [7:0]  PER   = 8'(2 * HALF_TICKS);
  localparam logic [7:0]  HALF  = 8'(HALF_TICKS);
  localparam logic [7:0]  QTR   = 8'(DRSS_READ_DEG * 2 * HALF_TICKS / DRSS_FULL_DEG);
  localparam logic [7:0]  WQTR  = 8'((-DRSS_WRITE_DEG) * 2 * HALF_TICKS / DRSS_FULL_DEG);
  localparam int          SDLY0 = (DRSS_STROBE_DEG * 2 * HALF_TICKS + DRSS_FULL_DEG - 1)
                                  / DRSS_FULL_DEG;
  localparam int          SDLY  = (SDLY0 < 1) ? 1 : SDLY0;
  localparam logic [15:0] TMO   = 16'(TIMEOUT_TICKS);
  localparam logic [7:0]  BURST = 8'(BURST_PAIRS);

  typedef enum logic [2:0] {
    DRSS_ST_IDLE,
    DRSS_ST_ISSUE,
    DRSS_ST_WAIT_STROBE,
    DRSS_ST_WAIT_RISE,
    DRSS_ST_COUNT,
    DRSS_ST_STREAM
  } drss_state_t;

  function automatic logic [7:0] wrap(input logic [9:0] v);
    wrap = 8'(v % {2'h0, PER});
  endfunction : wrap

  drss_state_t          state;
  logic [31:0]          ctrl;
  logic [31:0]          window;
  logic [31:0]          act_ctrl;
  logic [15:0]          done_count;
  logic [15:0]          tmo_count;
  logic [7:0]           ph;
  logic [7:0]           next_ph;
  logic                 dqs_s1, dqs_s2, fb_s1, fb_s2, fb_q;
  logic [DQ_WIDTH-1:0]  dq_s1, dq_s2;
  logic [SDLY-1:0]      dqs_dly;
  logic                 dqs_sh_q;
  logic [7:0]           fb_phase;
  logic [7:0]           rd_pos;
  logic                 cap_rise, cap_fall;
  logic [DQ_WIDTH-1:0]  hi_cap, pair_hi, pair_lo;
  logic [3:0]           cyc;
  logic [3:0]           lat_cnt;
  logic [15:0]          wait_cnt;
  logic [7:0]           pairs;
  logic [7:0]           sample_pos;
  logic [7:0]           numcycle;
  logic [7:0]           auto_phase;
  logic                 edge_ok, wide_ok;
  drss_edge_t           auto_sel, sel;
  logic                 acc, wr_en;

  // System clock phase counter and generated clocks.
  always_comb begin
    next_ph = (ph == PER - 8'h01) ? 8'h00 : ph + 8'h01;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ph                          <= 8'h00;
      SYS_CLK_OUT                 <= 1'b0;
      WRITE_CLK_OUT               <= 1'b0;
      LOOPBACK_FEEDBACK_CLOCK_OUT <= 1'b0;
    end else begin
      ph                          <= next_ph;
      SYS_CLK_OUT                 <= next_ph < HALF; // [RULE15]
      // The write clock leads by a quarter period so DQ is centred on DQS.
      WRITE_CLK_OUT               <= wrap({2'h0, next_ph} + {2'h0, WQTR}) < HALF; // [RULE15]
      LOOPBACK_FEEDBACK_CLOCK_OUT <= next_ph < HALF; // [RULE15]
    end
  end

  // Pin synchronisers.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      fb_s1  <= 1'b0;
      fb_s2  <= 1'b0;
      dq_s1  <= '0;
      dq_s2  <= '0;
    end else begin
      dqs_s1 <= DQS_IN;
      dqs_s2 <= dqs_s1;
      fb_s1  <= LOOPBACK_FEEDBACK_CLOCK_IN;
      fb_s2  <= fb_s1;
      dq_s1  <= DQ_IN;
      dq_s2  <= dq_s1;
    end
  end

  // Strobe phase shift and feedback phase tracking.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dqs_dly  <= '0;
      dqs_sh_q <= 1'b0;
      fb_q     <= 1'b0;
      fb_phase <= 8'h00;
    end else begin
      dqs_dly  <= {dqs_dly[SDLY-2:0], dqs_s2}; // [RULE1]
      dqs_sh_q <= dqs_dly[SDLY-1];
      fb_q     <= fb_s2;
      if (fb_s2 && !fb_q) begin
        fb_phase <= ph; // [RULE16]
      end
    end
  end

  // The read clock sits a quarter period after the looped feedback edge plus a skew trim.
  always_comb begin
    rd_pos = wrap({2'h0, fb_phase} + {2'h0, QTR}
                  + {2'h0, act_ctrl[DRSS_CTRL_ADJ_LSB +: 8]}); // [RULE18]
  end

  always_comb begin
    if (act_ctrl[DRSS_CTRL_STROBELESS]) begin
      cap_rise = (ph == rd_pos); // [RULE17]
      cap_fall = (ph == wrap({2'h0, rd_pos} + {2'h0, HALF})); // [RULE17]
    end else begin
      cap_rise = dqs_dly[SDLY-1] && !dqs_sh_q; // [RULE1]
      cap_fall = !dqs_dly[SDLY-1] && dqs_sh_q; // [RULE3]
    end
  end

  // Capture stage: the high word is realigned with the low word on the falling edge.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hi_cap  <= '0;
      pair_hi <= '0;
      pair_lo <= '0;
    end else begin
      if (cap_rise) begin
        hi_cap <= dq_s2; // [RULE1]
      end
      if (cap_fall) begin
        pair_hi <= hi_cap; // [RULE1]
        pair_lo <= dq_s2; // [RULE3]
      end
    end
  end

  // Resynchronization edge selection from the safe window.
  always_comb begin
    logic [31:0] min_v;
    logic [31:0] max_v;
    logic [31:0] nc;
    logic [31:0] shift;
    min_v = 32'(window[DRSS_WIN_MIN_LSB +: 16]);
    max_v = 32'(window[DRSS_WIN_MAX_LSB +: 16]);
    nc    = (min_v + 32'(HALF_TICKS) - 32'd1) / 32'(HALF_TICKS); // [RULE5]
    numcycle = 8'(nc);
    edge_ok  = (nc * 32'(HALF_TICKS)) < max_v; // [RULE6]
    wide_ok  = (max_v > min_v)
               && ((max_v - min_v) * 32'(DRSS_CLK_PERIOD_PS) > 32'(DRSS_PLL_SKEW_PS)); // [RULE10]
    shift    = (nc == 32'd0) ? 32'd0 : min_v - (nc - 32'd1) * 32'(HALF_TICKS);
    // An even count puts the nearest edge on the falling side, so add half a period.
    if (!nc[0]) begin
      auto_phase = wrap(10'(shift) + {2'h0, HALF}); // [RULE9] [RULE11]
    end else begin
      auto_phase = wrap(10'(shift)); // [RULE9]
    end
    if (!edge_ok) begin
      auto_sel = DRSS_EDGE_SHIFT; // [RULE6] [RULE14]
    end else if (!nc[0]) begin
      auto_sel = DRSS_EDGE_RISE; // [RULE7]
    end else begin
      auto_sel = DRSS_EDGE_FALL; // [RULE8]
    end
  end

  always_comb begin
    logic [7:0] man_phase;
    man_phase = wrap({2'h0, act_ctrl[DRSS_CTRL_PHASE_LSB +: 8]});
    if (act_ctrl[DRSS_CTRL_AUTO]) begin
      sel = auto_sel;
    end else begin
      sel = drss_edge_t'(act_ctrl[DRSS_CTRL_SEL_LSB +: 2]);
    end
    unique case (sel)
      DRSS_EDGE_RISE:      sample_pos = 8'h00; // [RULE2]
      DRSS_EDGE_FALL:      sample_pos = HALF; // [RULE2]
      DRSS_EDGE_SHIFT:     sample_pos = act_ctrl[DRSS_CTRL_AUTO] ? auto_phase
                                                                  : man_phase; // [RULE14]
      DRSS_EDGE_SHIFT_INV: sample_pos = wrap({2'h0, man_phase} + {2'h0, HALF}); // [RULE2]
    endcase
  end

  // Read sequencing from command to the last resynchronized pair.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state        <= DRSS_ST_IDLE;
      MEM_READ_CMD <= 1'b0;
      cyc          <= 4'h0;
      lat_cnt      <= 4'h0;
      wait_cnt     <= 16'h0000;
      pairs        <= 8'h00;
      done_count   <= 16'h0000;
      tmo_count    <= 16'h0000;
    end else begin
      if (ph == PER - 8'h01 && state != DRSS_ST_ISSUE) begin
        MEM_READ_CMD <= 1'b0;
      end
      unique case (state)
        DRSS_ST_IDLE: begin
          if (READ_REQ) begin
            state <= DRSS_ST_ISSUE;
          end
        end
        DRSS_ST_ISSUE: begin
          // The command goes out for one system period starting at a rising edge.
          if (ph == PER - 8'h01) begin
            MEM_READ_CMD <= 1'b1; // [RULE4]
            lat_cnt      <= 4'h0;
            wait_cnt     <= 16'h0000;
            state        <= DRSS_ST_WAIT_STROBE;
          end
        end
        DRSS_ST_WAIT_STROBE: begin
          wait_cnt <= wait_cnt + 16'h0001;
          if (ph == PER - 8'h01 && lat_cnt != 4'hf) begin
            lat_cnt <= lat_cnt + 4'h1;
          end
          if (wait_cnt == TMO) begin
            tmo_count <= tmo_count + 16'h0001;
            state     <= DRSS_ST_IDLE;
          end else if (cap_fall && (!act_ctrl[DRSS_CTRL_STROBELESS]
                       || lat_cnt >= act_ctrl[DRSS_CTRL_LAT_LSB +: 4])) begin
            state <= DRSS_ST_WAIT_RISE; // [RULE12]
          end
        end
        DRSS_ST_WAIT_RISE: begin
          if (ph == PER - 8'h01) begin
            cyc   <= 4'h0; // [RULE12]
            state <= DRSS_ST_COUNT;
          end
        end
        DRSS_ST_COUNT: begin
          if (ph == sample_pos && cyc == act_ctrl[DRSS_CTRL_CYC_LSB +: 4]) begin
            pairs <= 8'h01;
            state <= (BURST == 8'h01) ? DRSS_ST_IDLE : DRSS_ST_STREAM;
            if (BURST == 8'h01) begin
              done_count <= done_count + 16'h0001;
            end
          end else if (ph == PER - 8'h01) begin
            cyc <= cyc + 4'h1; // [RULE13]
          end
        end
        DRSS_ST_STREAM: begin
          if (ph == sample_pos) begin
            pairs <= pairs + 8'h01;
            if (pairs == BURST - 8'h01) begin
              done_count <= done_count + 16'h0001;
              state      <= DRSS_ST_IDLE;
            end
          end
        end
        default: state <= DRSS_ST_IDLE;
      endcase
    end
  end

  // Register B: both words move into the system domain on the same edge.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RD_DATA  <= '0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      if (ph == sample_pos && ((state == DRSS_ST_STREAM) || (state == DRSS_ST_COUNT
          && cyc == act_ctrl[DRSS_CTRL_CYC_LSB +: 4]))) begin
        RD_DATA  <= {pair_hi, pair_lo}; // [RULE19]
        RD_VALID <= 1'b1; // [RULE19]
      end
    end
  end

  always_comb begin
    READ_BUSY = (state != DRSS_ST_IDLE);
  end

  // APB slave with no wait states.
  always_comb begin
    acc     = PSEL && PENABLE;
    wr_en   = acc && PWRITE;
    PREADY  = 1'b1;
    PSLVERR = acc && !(PADDR == DRSS_OFS_CTRL || PADDR == DRSS_OFS_WINDOW
                       || PADDR == DRSS_OFS_STATUS || PADDR == DRSS_OFS_COUNT);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl   <= DRSS_CTRL_RESET;
      window <= DRSS_WINDOW_RESET;
    end else if (wr_en) begin
      if (PADDR == DRSS_OFS_CTRL) begin
        ctrl <= PWDATA;
      end
      if (PADDR == DRSS_OFS_WINDOW) begin
        window <= PWDATA;
      end
    end
  end

  // Software may write at any time; a read in flight keeps the control settings it started with, but window writes apply at once.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      act_ctrl <= DRSS_CTRL_RESET;
    end else if (state == DRSS_ST_IDLE) begin
      act_ctrl <= ctrl; // [RULE20]
    end
  end

  // Read data is latched in the setup cycle so it stands through the access cycle.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        DRSS_OFS_CTRL:   PRDATA <= ctrl;
        DRSS_OFS_WINDOW: PRDATA <= window;
        DRSS_OFS_STATUS: begin
          PRDATA                                <= 32'h0000_0000;
          PRDATA[DRSS_ST_NUMCYC_LSB +: 8]       <= numcycle;
          PRDATA[DRSS_ST_EDGE_OK]               <= edge_ok;
          PRDATA[DRSS_ST_WIDE_OK]               <= wide_ok;
          PRDATA[DRSS_ST_SEL_LSB +: 2]          <= sel;
          PRDATA[DRSS_ST_BUSY]                  <= READ_BUSY;
          PRDATA[DRSS_ST_FBPH_LSB +: 8]         <= fb_phase;
          PRDATA[DRSS_ST_PHASE_LSB +: 8]        <= sample_pos;
        end
        DRSS_OFS_COUNT:  PRDATA <= {tmo_count, done_count};
        default:         PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule : drss_top

// *** drss_checker.sv ***
// Checker for the DDR read resynchronization block.
// Assumes a bind to drss_top with HALF_TICKS of 4; it sees only that module's ports.
module drss_checker
  import drss_pkg::*;
#(
  parameter int DQ_WIDTH = 8
) (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  RESET,
  // Watched outputs
  input wire logic                  READ_BUSY,
  input wire logic                  MEM_READ_CMD,
  input wire logic                  SYS_CLK_OUT,
  input wire logic                  WRITE_CLK_OUT,
  input wire logic                  LOOPBACK_FEEDBACK_CLOCK_OUT,
  input wire logic [2*DQ_WIDTH-1:0] RD_DATA,
  input wire logic                  RD_VALID,
  input wire logic                  PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // The lead check needs two edges of history taken after release.
  logic [1:0] settle;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end
  // The first high phase after release is one tick short, so the period check waits for it.
  sys_clk_period_a: assert property (settle == 2'h3 && $rose(SYS_CLK_OUT) |->
    SYS_CLK_OUT[*4] ##1 !SYS_CLK_OUT[*4] ##1 SYS_CLK_OUT) else $error("system clock period");
  feedback_copy_a: assert property (LOOPBACK_FEEDBACK_CLOCK_OUT == SYS_CLK_OUT)
    else $error("feedback clock differs from system clock");
  write_clk_lead_a: assert property (settle == 2'h3 |->
    SYS_CLK_OUT == $past(WRITE_CLK_OUT, 2)) else $error("write clock lead wrong");
  read_cmd_edge_a: assert property ($rose(MEM_READ_CMD) |-> $rose(SYS_CLK_OUT))
    else $error("read command off the system rising edge");
  read_cmd_len_a: assert property ($rose(MEM_READ_CMD) |->
    MEM_READ_CMD[*8] ##1 !MEM_READ_CMD) else $error("read command length");
  busy_to_cmd_a: assert property ($rose(READ_BUSY) |-> ##[0:8] $rose(MEM_READ_CMD))
    else $error("no read command after request");
  valid_spacing_a: assert property (RD_VALID |=> !RD_VALID[*7])
    else $error("read pairs closer than one system period");
  pair_hold_a: assert property (RD_VALID |=> ($stable(RD_DATA))[*7])
    else $error("read pair changed between pulses");
  cover property ($rose(MEM_READ_CMD));
  cover property (RD_VALID);
  cover property (PSLVERR);
endmodule : drss_checker

bind drss_top drss_checker #(.DQ_WIDTH(DQ_WIDTH)) u_drss_checker (
  .CLK(CLK), .RESET(RESET), .READ_BUSY(READ_BUSY), .MEM_READ_CMD(MEM_READ_CMD),
  .SYS_CLK_OUT(SYS_CLK_OUT), .WRITE_CLK_OUT(WRITE_CLK_OUT),
  .LOOPBACK_FEEDBACK_CLOCK_OUT(LOOPBACK_FEEDBACK_CLOCK_OUT), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .PSLVERR(PSLVERR));

// *** drss_mem_model.sv ***
// Behavioural model of the memory that answers reads with data and strobe.
// Assumes read_cmd comes from the block on clk; times are counted in clk ticks.
module drss_mem_model
  import drss_pkg::*;
#(
  parameter int DQ_WIDTH    = 8,
  parameter int HALF_TICKS  = 4,
  parameter int BURST_PAIRS = 4,
  parameter int CAS_PERIODS = 2
) (
  // Clock and command
  input wire logic                clk,
  input wire logic                read_cmd,
  // Scenario knobs
  input wire logic                mute,
  input wire logic                strobe_off,
  // Read pins
  output logic                    dqs,
  output logic [DQ_WIDTH-1:0]     dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmd_q;
  always @(posedge clk) cmd_q <= read_cmd;
  // The strobe line has a pull-down, so it rests low; released data shows the inverse.
  initial begin
    dqs = 1'b0;
    dq  = '0;
    forever begin
      @(posedge clk);
      if (read_cmd && !cmd_q && !mute) begin
        repeat (2 * HALF_TICKS * CAS_PERIODS) @(posedge clk);
        for (int k = 0; k < BURST_PAIRS; k++) begin
          dqs <= !strobe_off;
          dq  <= DQ_WIDTH'(32'ha0 + k);
          repeat (HALF_TICKS) @(posedge clk);
          dqs <= 1'b0;
          dq  <= DQ_WIDTH'(32'h50 + k);
          repeat (HALF_TICKS) @(posedge clk);
        end
        dq <= ~dq;
      end
    end
  end
endmodule : drss_mem_model

// *** test_ddr_read_resync_select.sv ***
// Self-checking bench for the DDR read resynchronization block.
// Assumes drss_top, the memory model and the bound checker are compiled before it.
module test_ddr_read_resync_select
  import drss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HT = 4;
  localparam int BP = 4;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, dq;
  logic [31:0] pwdata, prdata;
  logic        read_req, read_busy, mem_cmd, dqs, sys_clk, wr_clk, loopback_feedback_clock;
  logic [15:0] rd_data;
  logic        rd_valid, mute, strobe_off;
  logic        cmd_d = 1'b0;
  int          bad_count, tests_run;
  int          cyc = 0, cmd_at = 0, cmd_n = 0;

  drss_top #(.DQ_WIDTH(8), .HALF_TICKS(HT), .BURST_PAIRS(BP), .TIMEOUT_TICKS(64)) dut (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .READ_REQ(read_req), .READ_BUSY(read_busy), .MEM_READ_CMD(mem_cmd), .DQS_IN(dqs),
    .DQ_IN(dq), .SYS_CLK_OUT(sys_clk), .WRITE_CLK_OUT(wr_clk),
    .LOOPBACK_FEEDBACK_CLOCK_OUT(loopback_feedback_clock), .LOOPBACK_FEEDBACK_CLOCK_IN(loopback_feedback_clock),
    .RD_DATA(rd_data), .RD_VALID(rd_valid));
  drss_mem_model #(.DQ_WIDTH(8), .HALF_TICKS(HT), .BURST_PAIRS(BP)) u_mem (
    .clk(clk), .read_cmd(mem_cmd), .mute(mute), .strobe_off(strobe_off), .dqs(dqs), .dq(dq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cmd_d <= mem_cmd;
    if (mem_cmd && !cmd_d) begin
      cmd_at <= cyc;
      cmd_n <= cmd_n + 1;
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check

  // One idle edge follows each transfer so no signal is driven twice in a step.
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb_xfer

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask : apb_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe, string m);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, a, 32'h0, r, e);
    check(r === x && e === xe, m);
  endtask : rd_chk

  task automatic t_regs();
    rd_chk(DRSS_OFS_CTRL, DRSS_CTRL_RESET, 1'b0, "control reset value");
    rd_chk(DRSS_OFS_WINDOW, DRSS_WINDOW_RESET, 1'b0, "window reset value");
    rd_chk(8'h10, 32'h0, 1'b1, "unmapped access");
    apb_wr(DRSS_OFS_CTRL, 32'h0000_0510);
    rd_chk(DRSS_OFS_CTRL, 32'h0000_0510, 1'b0, "control readback");
  endtask : t_regs

  task automatic t_auto();
    int e [4] = '{13, 9, 13, 20};
    int l [4] = '{20, 14, 15, 20};
    int nc, ph;
    logic ok, err;
    logic [31:0] s;
    apb_wr(DRSS_OFS_CTRL, DRSS_CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      apb_wr(DRSS_OFS_WINDOW, {16'(l[i]), 16'(e[i])});
      apb_xfer(1'b0, DRSS_OFS_STATUS, 32'h0, s, err);
      nc = (e[i] + HT - 1) / HT;
      ok = nc * HT < l[i];
      ph = e[i] - (nc - 1) * HT + ((nc % 2 == 0) ? HT : 0);
      check(s[7:0] === 8'(nc), "half-cycle count");
      check(s[8] === ok, "edge in window");
      check(s[9] === ((l[i] - e[i]) * DRSS_CLK_PERIOD_PS > DRSS_PLL_SKEW_PS), "width");
      if (ok) check(s[11:10] === (nc[0] ? DRSS_EDGE_FALL : DRSS_EDGE_RISE), "edge");
      else check(s[31:24] === 8'(ph), "extra clock phase");
    end
  endtask : t_auto

  // Returns the ticks from the read command to the first pair.
  task automatic run_read(input logic [31:0] ctrl, input int pairs, input int skip,
                          output int first);
    int n, got, c0, k;
    apb_wr(DRSS_OFS_CTRL, ctrl);
    c0 = cmd_n;
    n = 0;
    got = 0;
    first = -1;
    read_req <= 1'b1;
    @(posedge clk);
    read_req <= 1'b0;
    while (got < pairs && n < 400) begin
      @(posedge clk);
      n++;
      read_req <= (n == 24);
      if (rd_valid === 1'b1) begin
        k = (got + skip < pairs) ? got + skip : pairs - 1;
        if (first < 0) first = cyc - cmd_at;
        check(rd_data === {8'ha0 + 8'(k), 8'h50 + 8'(k)}, "pair");
        got++;
      end
    end
    while (read_busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(got == pairs && cmd_n - c0 == 1, "burst count");
  endtask : run_read

  task automatic t_edges();
    int sel [5] = '{0, 0, 1, 2, 3};
    int cy [5] = '{0, 1, 0, 0, 0};
    int ph [5] = '{0, 0, 0, 2, 2};
    int off [5] = '{0, 2 * HT, HT, 2, 2 + HT};
    int f0, f;
    // Cycle zero opens one tick before the second pair lands, so any later sampling point
    // starts on the second pair and repeats the last one.
    for (int i = 0; i < 5; i++) begin
      run_read(32'(sel[i] << 2 | cy[i] << 4 | ph[i] << 8), BP, int'(off[i] > 0), f);
      if (i == 0) f0 = f;
      check(f - f0 == off[i], "sampling point");
    end
  endtask : t_edges

  task automatic t_strobeless();
    int f;
    strobe_off <= 1'b1;
    // The model's first low word is captured three system periods after the command.
    run_read(32'h0300_0001, BP, 0, f);
    strobe_off <= 1'b0;
  endtask : t_strobeless

  task automatic t_timeout();
    logic [31:0] c0, c1;
    logic e;
    int n, seen;
    // Back to strobe capture, otherwise the read clock would still end the silent read.
    apb_wr(DRSS_OFS_CTRL, 32'h0000_0000);
    apb_xfer(1'b0, DRSS_OFS_COUNT, 32'h0, c0, e);
    check(c0[15:0] === 16'h0006, "completed reads");
    n = 0;
    seen = 0;
    mute <= 1'b1;
    read_req <= 1'b1;
    @(posedge clk);
    read_req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      seen += int'(rd_valid === 1'b1);
    end while (read_busy !== 1'b0 && n < 300);
    check(seen == 0 && n < 300, "silent read ended");
    apb_xfer(1'b0, DRSS_OFS_COUNT, 32'h0, c1, e);
    check(c1 === {c0[31:16] + 16'h1, c0[15:0]}, "timeout count");
    mute <= 1'b0;
  endtask : t_timeout

  initial begin
    {psel, penable, pwrite, read_req, mute, strobe_off} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_auto();
    t_edges();
    t_strobeless();
    t_timeout();
    complete_run();
  end

  // The whole run needs under a thousand cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : test_ddr_read_resync_select
